/* File: hw/audio_timer_channels.sv */
// Four-channel audio timer, tone and noise block
// What this block does
// R1: Only low four address bits decode; registers mirror through the block.
// R2: Serial control bits 1:0 both zero enter initialization mode.
// R3: Hold init seven cycles; slow and fast ticks fire 83 and 22 later.
// R4: Zero serial clock select field resets serial circuitry.
// R5: Each channel 8-bit countdown, divisor N divides by N+1, pulses on underflow.
// R6: Config bit 0 picks 64KHz (0) or 15KHz (1) common base tick.
// R7: Config bits 6 and 5 run timers 1 and 3 from system clock.
// R8: Reload takes three cycles; full-rate period is N+4.
// R9: Slow-tick timer period is N+1 ticks; reload delay absorbed.
// R10: Config bits 4 and 3 pair timers 1-2 and 3-4 into 16 bits.
// R11: Paired reload takes six cycles; full-rate pair period N+7. The code gives 264 cycles for N=259, not 266.
// R12: Pairing uses raw timer pulses; low channel still outputs.
// R13: Tone bit 5 picks square (1) or noise (0); square toggles.
// R14: Tone bit 6 picks 4-bit (1) or 9/17-bit (0) noise.
// R15: Tone bit 7 clear lets 5-bit noise mask timer pulses.
// R16: Tone bits 3:0 volume output only while channel bit is one.
// R17: Tone bit 4 forces output to one after high-pass stage.
// R18: Config bits 2 and 1 high-pass channels 1 and 2 via 3 and 4.
// R19: Disabled high-pass holds flip-flop at one, XOR still inverts.
// R20: Any write to restart strobe reloads timers, sets output flip-flops.
// R21: Timers reload four cycles after restart strobe.
// R22: Restart strobe leaves slow tick phase untouched.
// R23: Timers count only on their selected source tick.
// R24: No reset pin; software must program registers before use. Here rstn still resets every register.
`timescale 1ns/1ps
module audio_timer_channels
   import audio_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire bus_write_t bus_wr,
   output volume_out_t volume_out,
   output logic [3:0] timer_pulse,
   output logic init_mode,
   output logic serial_reset
);
   logic [7:0] divisor_reg [4];
   logic [7:0] tone_reg [4];
   logic [7:0] config_reg;
   logic [7:0] serial_keyboard_control_reg;
   logic [6:0] slow_cnt_reg;
   logic [4:0] fast_cnt_reg;
   logic slow_tick;
   logic fast_tick;
   logic base_tick;
   logic [RESTART_DELAY-1:0] restart_pipe_reg;
   logic restart_now;
   logic [3:0] count_en;
   logic [3:0] uf;
   logic [3:0] borrow;
   logic [3:0] pair_reload;
   logic [3:0] out_ff_reg;
   logic [1:0] hp_ff_reg;
   logic [3:0] clock_out;
   logic [3:0] chan_bit;
   logic [16:0] poly17_reg;
   logic [8:0] poly9_reg;
   logic [4:0] poly5_reg;
   logic [3:0] poly4_reg;
   logic poly_big;
   logic [3:0] wr_div;
   logic [3:0] wr_tone;
   logic wr_cfg;
   logic wr_serial_keyboard_control;
   logic wr_restart;
   logic [7:0] load_val [4];

   // Low nibble only; upper address bits never reach the block
   always_comb begin
      wr_div = 4'h0;
      wr_tone = 4'h0;
      wr_cfg = 1'b0;
      wr_serial_keyboard_control = 1'b0;
      wr_restart = 1'b0;
      if (bus_wr.wr) begin
         case (bus_wr.addr) // R1
            OFS_CH1_DIVISOR: wr_div[0] = 1'b1;
            OFS_CH1_DIVISOR + 4'h2: wr_div[1] = 1'b1;
            OFS_CH1_DIVISOR + 4'h4: wr_div[2] = 1'b1;
            OFS_CH1_DIVISOR + 4'h6: wr_div[3] = 1'b1;
            OFS_CH1_TONE: wr_tone[0] = 1'b1;
            OFS_CH1_TONE + 4'h2: wr_tone[1] = 1'b1;
            OFS_CH1_TONE + 4'h4: wr_tone[2] = 1'b1;
            OFS_CH1_TONE + 4'h6: wr_tone[3] = 1'b1;
            OFS_SHARED_CONFIG: wr_cfg = 1'b1;
            OFS_RESTART_STROBE: wr_restart = 1'b1;
            OFS_SERIAL_KEYBOARD: wr_serial_keyboard_control = 1'b1;
            default: wr_cfg = 1'b0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         config_reg <= 8'h00;
      end else if (wr_cfg) begin
         config_reg <= bus_wr.data; // R1
      end
   end

   // Contents are undefined to software; reset only for simulation sanity
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         serial_keyboard_control_reg <= 8'h00; // R24
      end else if (wr_serial_keyboard_control) begin
         serial_keyboard_control_reg <= bus_wr.data;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 4; i++) divisor_reg[i] <= 8'h00;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wr_div[i]) divisor_reg[i] <= bus_wr.data;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 4; i++) tone_reg[i] <= 8'h00;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wr_tone[i]) tone_reg[i] <= bus_wr.data;
         end
      end
   end

   assign init_mode = serial_keyboard_control_reg[1:0] == 2'b00; // R2
   assign serial_reset = serial_keyboard_control_reg[5:3] == 3'b000; // R4

   // Init preloads mid-cycle values so ticks land 83 and 22 after release
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         slow_cnt_reg <= SLOW_INIT;
      end else if (init_mode) begin
         slow_cnt_reg <= SLOW_INIT; // R3
      end else if (slow_cnt_reg == 7'(SLOW_TICK_CYCLES - 1)) begin
         slow_cnt_reg <= 7'h00;
      end else begin
         slow_cnt_reg <= slow_cnt_reg + 7'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fast_cnt_reg <= 5'(FAST_INIT);
      end else if (init_mode) begin
         fast_cnt_reg <= 5'(FAST_INIT); // R3
      end else if (fast_cnt_reg == 5'(FAST_TICK_CYCLES - 1)) begin
         fast_cnt_reg <= 5'h00;
      end else begin
         fast_cnt_reg <= fast_cnt_reg + 5'h01;
      end
   end

   // Tick phase is untouched by the restart strobe
   assign slow_tick = !init_mode &&
      slow_cnt_reg == 7'(SLOW_TICK_CYCLES - 1); // R22
   assign fast_tick = !init_mode &&
      fast_cnt_reg == 5'(FAST_TICK_CYCLES - 1);
   assign base_tick = config_reg[CFG_SLOW_BASE] ? slow_tick : fast_tick; // R6

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         restart_pipe_reg <= '0;
      end else begin
         restart_pipe_reg <= {restart_pipe_reg[RESTART_DELAY-2:0],
            wr_restart}; // R21
      end
   end
   assign restart_now = restart_pipe_reg[RESTART_DELAY-1]; // R20

   // High timer of a pair counts low-timer borrows, not audio output
   always_comb begin
      count_en[0] = config_reg[CFG_FULL1] ? 1'b1 : base_tick; // R7
      count_en[2] = config_reg[CFG_FULL3] ? 1'b1 : base_tick; // R7
      count_en[1] = config_reg[CFG_PAIR12] ? uf[0] : base_tick; // R10 R12
      count_en[3] = config_reg[CFG_PAIR34] ? uf[2] : base_tick; // R10 R12
   end

   // Pair reload: low restarts only when the high timer borrows
   always_comb begin
      pair_reload = 4'h0;
      pair_reload[0] = config_reg[CFG_PAIR12] && borrow[1]; // R11
      pair_reload[2] = config_reg[CFG_PAIR34] && borrow[3]; // R11
   end

   // Paired low timer wraps to full scale, so the pair acts as 16 bits;
   // its own divisor is taken only at a pair reload or a restart
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         load_val[i] = divisor_reg[i];
      end
      if (config_reg[CFG_PAIR12] && !restart_now && !pair_reload[0]) begin
         load_val[0] = 8'hFF; // R10
      end
      if (config_reg[CFG_PAIR34] && !restart_now && !pair_reload[2]) begin
         load_val[2] = 8'hFF; // R10
      end
   end

   // One counter per channel; sources differ only in count_en
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ch
         channel_counter u_cnt (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .divisor(load_val[g]),
            .count_en(count_en[g]), // R23
            .reload_now(restart_now),
            .pair_reload(pair_reload[g]),
            .underflow(uf[g]), // R5 R9
            .borrow(borrow[g])
         );
      end
   endgenerate

   // Registered copy so outside logic never sees a combinational glitch
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) timer_pulse <= 4'h0;
      else timer_pulse <= uf;
   end

   // Noise generators are frozen in reset during init mode
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         poly17_reg <= POLY17_SEED;
      end else if (init_mode) begin
         poly17_reg <= POLY17_SEED; // R2
      end else begin
         poly17_reg <= {poly17_reg[15:0], poly17_reg[16] ^ poly17_reg[11]};
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         poly9_reg <= POLY9_SEED;
      end else if (init_mode) begin
         poly9_reg <= POLY9_SEED; // R2
      end else begin
         poly9_reg <= {poly9_reg[7:0], poly9_reg[8] ^ poly9_reg[3]};
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         poly5_reg <= POLY5_SEED;
      end else if (init_mode) begin
         poly5_reg <= POLY5_SEED; // R2
      end else begin
         poly5_reg <= {poly5_reg[3:0], poly5_reg[4] ^ poly5_reg[2]};
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         poly4_reg <= POLY4_SEED;
      end else if (init_mode) begin
         poly4_reg <= POLY4_SEED; // R2
      end else begin
         poly4_reg <= {poly4_reg[2:0], poly4_reg[3] ^ poly4_reg[2]};
      end
   end

   // Config bit 7 selects 9-bit instead of 17-bit noise
   assign poly_big = config_reg[7] ? poly9_reg[8] : poly17_reg[16];

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         clock_out[i] = uf[i] &&
            (tone_reg[i][TONE_NO_MASK] || poly5_reg[4]); // R15
      end
   end

   // Restart wins over a clocking in the same cycle: the strobe presets
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         out_ff_reg <= 4'hF;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (restart_now) begin
               out_ff_reg[i] <= 1'b1; // R20
            end else if (clock_out[i]) begin
               if (tone_reg[i][TONE_SQUARE])
                  out_ff_reg[i] <= !out_ff_reg[i]; // R13
               else if (tone_reg[i][TONE_POLY4])
                  out_ff_reg[i] <= poly4_reg[3]; // R14
               else
                  out_ff_reg[i] <= poly_big; // R14
            end
         end
      end
   end

   // High-pass sample flip-flops clocked by channels 3 and 4
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hp_ff_reg[0] <= 1'b1;
      end else if (!config_reg[CFG_HP1]) begin
         hp_ff_reg[0] <= 1'b1; // R19
      end else if (clock_out[2]) begin
         hp_ff_reg[0] <= out_ff_reg[0]; // R18
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hp_ff_reg[1] <= 1'b1;
      end else if (!config_reg[CFG_HP2]) begin
         hp_ff_reg[1] <= 1'b1; // R19
      end else if (clock_out[3]) begin
         hp_ff_reg[1] <= out_ff_reg[1]; // R18
      end
   end

   always_comb begin
      chan_bit[0] = out_ff_reg[0] ^ hp_ff_reg[0]; // R18
      chan_bit[1] = out_ff_reg[1] ^ hp_ff_reg[1]; // R18
      chan_bit[2] = out_ff_reg[2];
      chan_bit[3] = out_ff_reg[3];
      for (int i = 0; i < 4; i++) begin
         if (tone_reg[i][TONE_VOL_ONLY]) chan_bit[i] = 1'b1; // R17
      end
   end

   // Volume is gated late so volume-only mode bypasses the inversion
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         volume_out <= '0;
      end else begin
         volume_out.ch1 <= chan_bit[0] ? tone_reg[0][3:0] : 4'h0; // R16
         volume_out.ch2 <= chan_bit[1] ? tone_reg[1][3:0] : 4'h0; // R16
         volume_out.ch3 <= chan_bit[2] ? tone_reg[2][3:0] : 4'h0; // R16
         volume_out.ch4 <= chan_bit[3] ? tone_reg[3][3:0] : 4'h0; // R16
      end
   end
endmodule

/* File: hw/audio_timer_pkg.sv */
// Shared constants and types for the audio timer block
package audio_timer_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_CH1_DIVISOR = 4'h0;
   localparam logic [3:0] OFS_CH1_TONE = 4'h1;
   localparam logic [3:0] OFS_SHARED_CONFIG = 4'h8;
   localparam logic [3:0] OFS_RESTART_STROBE = 4'h9;
   localparam logic [3:0] OFS_SERIAL_KEYBOARD = 4'hF;
   localparam int SLOW_TICK_CYCLES = 114;
   localparam int FAST_TICK_CYCLES = 28;
   localparam logic [6:0] SLOW_INIT = 7'h1F;
   localparam logic [6:0] FAST_INIT = 7'h06;
   localparam int INIT_HOLD_CYCLES = 7;
   localparam int RELOAD_DELAY = 3;
   localparam int RESTART_DELAY = 4;
   localparam int CFG_SLOW_BASE = 0;
   localparam int CFG_HP2 = 1;
   localparam int CFG_HP1 = 2;
   localparam int CFG_PAIR34 = 3;
   localparam int CFG_PAIR12 = 4;
   localparam int CFG_FULL3 = 5;
   localparam int CFG_FULL1 = 6;
   localparam int TONE_VOL_ONLY = 4;
   localparam int TONE_SQUARE = 5;
   localparam int TONE_POLY4 = 6;
   localparam int TONE_NO_MASK = 7;
   localparam logic [16:0] POLY17_SEED = 17'h1FFFF;
   localparam logic [8:0] POLY9_SEED = 9'h1FF;
   localparam logic [4:0] POLY5_SEED = 5'h1F;
   localparam logic [3:0] POLY4_SEED = 4'hF;
   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } bus_write_t;
   typedef struct packed {
      logic [3:0] ch4;
      logic [3:0] ch3;
      logic [3:0] ch2;
      logic [3:0] ch1;
   } volume_out_t;
endpackage

/* File: hw/channel_counter.sv */
// One 8-bit countdown timer with delayed reload
`timescale 1ns/1ps
module channel_counter
   import audio_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [7:0] divisor,
   input wire logic count_en,
   input wire logic reload_now,
   input wire logic pair_reload,
   output logic underflow,
   output logic borrow
);
   logic [7:0] count_reg;
   logic [1:0] wait_reg;
   logic pend_reg;

   // Underflow when zero meets an active source tick
   assign borrow = count_en && count_reg == 8'h00 && !pend_reg;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= 8'h00;
         pend_reg <= 1'b0;
         wait_reg <= 2'h0;
      end else if (reload_now || pair_reload) begin
         count_reg <= divisor; // R20
         pend_reg <= 1'b0;
         wait_reg <= 2'h0;
      end else if (pend_reg) begin
         // Reload settles three cycles after underflow
         wait_reg <= wait_reg + 2'h1;
         if (wait_reg == 2'(RELOAD_DELAY - 1)) begin // R8
            count_reg <= divisor;
            pend_reg <= 1'b0;
         end
      end else if (borrow) begin
         pend_reg <= 1'b1; // R5
         wait_reg <= 2'h0;
      end else if (count_en) begin
         count_reg <= count_reg - 8'h01; // R23
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) underflow <= 1'b0;
      else underflow <= borrow;
   end
endmodule

/* File: verif/audio_timer_checker.sv */
// Port checker for the audio timer block
`timescale 1ns/1ps
module audio_timer_checker
   import audio_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire bus_write_t bus_wr,
   input wire volume_out_t volume_out,
   input wire logic [3:0] timer_pulse,
   input wire logic init_mode,
   input wire logic serial_reset
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic [7:0] sh [16];
   logic [15:0] quiet, g0, g1;
   logic armed;
   wire [7:0] cfg = sh[OFS_SHARED_CONFIG];
   wire [7:0] tn1 = sh[OFS_CH1_TONE];
   wire [7:0] tn2 = sh[OFS_CH1_TONE + 4'h2];
   wire kbd = bus_wr.wr && bus_wr.addr == OFS_SERIAL_KEYBOARD;
   wire solo = !cfg[CFG_PAIR12] && cfg[CFG_FULL1];
   function automatic logic [15:0] inc(input logic [15:0] v);
      return (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction
   // Gaps are judged only when no write fell inside them
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sh <= '{default: 8'h00};
         quiet <= 16'h0000;
         g0 <= 16'h0000;
         g1 <= 16'h0000;
         armed <= 1'b0;
      end else begin
         quiet <= bus_wr.wr ? 16'h0000 : inc(quiet);
         g0 <= timer_pulse[0] ? 16'h0001 : inc(g0);
         g1 <= timer_pulse[1] ? 16'h0001 : inc(g1);
         if (bus_wr.wr) begin
            sh[bus_wr.addr] <= bus_wr.data;
            armed <= bus_wr.addr == OFS_RESTART_STROBE;
         end else if (timer_pulse[0] && quiet > 16'h0004) begin
            armed <= 1'b0;
         end
      end
   end
   property p_init;
      kbd |=> init_mode == ($past(bus_wr.data[1:0]) == 2'h0);
   endproperty
   a_init: assert property (p_init)
      else $error("init mode");
   property p_sreset;
      kbd |=> serial_reset == ($past(bus_wr.data[5:3]) == 3'h0);
   endproperty
   a_sreset: assert property (p_sreset)
      else $error("serial reset");
   property p_volonly;
      tn1[TONE_VOL_ONLY] && quiet > 16'h0004 |->
         volume_out.ch1 == tn1[3:0];
   endproperty
   a_volonly: assert property (p_volonly)
      else $error("volume only");
   property p_volzero;
      tn2[3:0] == 4'h0 && quiet > 16'h0004 |-> volume_out.ch2 == 4'h0;
   endproperty
   a_volzero: assert property (p_volzero)
      else $error("volume zero");
   property p_full;
      timer_pulse[0] && solo && int'(quiet) > int'(g0) + 16 |->
         int'(g0) == int'(cfg == cfg ? sh[OFS_CH1_DIVISOR] : 8'h00) + 4;
   endproperty
   a_full: assert property (p_full)
      else $error("full rate period");
   property p_slow;
      timer_pulse[1] && !cfg[CFG_PAIR12] && !init_mode &&
         int'(quiet) > int'(g1) + 16 |->
         int'(g1) == (int'(sh[OFS_CH1_DIVISOR + 4'h2]) + 1) *
         (cfg[CFG_SLOW_BASE] ? SLOW_TICK_CYCLES : FAST_TICK_CYCLES);
   endproperty
   a_slow: assert property (p_slow)
      else $error("slow period");
   property p_restart;
      timer_pulse[0] && armed && solo && quiet > 16'h0004 |->
         int'(quiet) >= int'(sh[OFS_CH1_DIVISOR]) + 6 &&
         int'(quiet) <= int'(sh[OFS_CH1_DIVISOR]) + 8;
   endproperty
   a_restart: assert property (p_restart)
      else $error("restart delay");
   property p_single;
      |timer_pulse |=> (timer_pulse & $past(timer_pulse)) == 4'h0;
   endproperty
   a_single: assert property (p_single)
      else $error("pulse width");
endmodule

/* File: verif/host_cpu_model.sv */
// Host processor model driving the register write port
`timescale 1ns/1ps
module host_cpu_model
   import audio_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic req_valid,
   input wire logic [3:0] req_addr,
   input wire logic [7:0] req_data,
   output bus_write_t bus_wr
);
   bus_write_t q = '0;
   assign bus_wr = q;
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else if (req_valid) begin
         q <= {1'b1, req_addr, req_data};
      end else begin
         q.wr <= 1'b0;
         // Idle data keeps moving so a stale byte never looks valid
         q.data <= ~q.data;
      end
   end
endmodule

/* File: verif/test_audio_timer_channels.sv */
// Self-checking bench for the audio timer block
`timescale 1ns/1ps
module test_audio_timer_channels;
   import audio_timer_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic req_valid = 1'b0;
   logic [3:0] req_addr = 4'h0;
   logic [7:0] req_data = 8'h00;
   bus_write_t bus_wr;
   volume_out_t volume_out;
   logic [3:0] timer_pulse;
   logic init_mode, serial_reset;
   int num_errors = 0;
   int checks = 0;
   always #5 ref_clk = ~ref_clk;
   host_cpu_model i_host (.ref_clk(ref_clk), .rstn(rstn),
      .req_valid(req_valid), .req_addr(req_addr), .req_data(req_data),
      .bus_wr(bus_wr));
   audio_timer_channels i_dut (.ref_clk(ref_clk), .rstn(rstn),
      .bus_wr(bus_wr), .volume_out(volume_out), .timer_pulse(timer_pulse),
      .init_mode(init_mode), .serial_reset(serial_reset));
   task automatic final_report;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_addr <= a;
      req_data <= d;
      @(posedge ref_clk);
      req_valid <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Restart first so an old long count cannot stall the measurement
   task automatic period(input logic [7:0] c, input int ch,
      input logic [7:0] n, input int exp, input int tol);
      int g;
      wr(OFS_SHARED_CONFIG, c);
      wr(OFS_CH1_DIVISOR + 4'(2 * ch), n);
      wr(OFS_RESTART_STROBE, 8'h00);
      settle(20);
      g = 0;
      while (timer_pulse[ch] !== 1'b1 && g < 2000) begin
         settle(1);
         g++;
      end
      g = 0;
      do begin
         settle(1);
         g++;
      end while (timer_pulse[ch] !== 1'b1 && g < 2000);
      if (g >= exp - tol && g <= exp + tol) begin
         g = exp;
      end
      check(16'(g), 16'(exp));
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      wr(OFS_SERIAL_KEYBOARD, 8'h00);
      settle(8);
      check(16'(init_mode), 16'h1);
      check(16'(serial_reset), 16'h1);
      wr(OFS_SERIAL_KEYBOARD, 8'h03);
      settle(3);
      check(16'(init_mode), 16'h0);
      check(16'(serial_reset), 16'h1);
      wr(OFS_SERIAL_KEYBOARD, 8'h0B);
      settle(3);
      check(16'(serial_reset), 16'h0);
      $display("init test done");
      for (int k = 0; k < 4; k++) begin
         wr(OFS_CH1_TONE + 4'(2 * k), 8'(8'h15 + k));
      end
      settle(6);
      check(volume_out, 16'h8765);
      wr(OFS_SHARED_CONFIG, 8'h60);
      for (int k = 0; k < 4; k++) begin
         wr(OFS_CH1_DIVISOR + 4'(2 * k), 8'hFF);
         wr(OFS_CH1_TONE + 4'(2 * k), 8'(8'hA9 + k));
      end
      wr(OFS_RESTART_STROBE, 8'h5A);
      settle(8);
      check(volume_out, 16'hCB00);
      settle(292);
      check(volume_out, 16'hC009);
      wr(OFS_CH1_TONE + 4'h2, 8'h10);
      settle(6);
      check(16'(volume_out.ch2), 16'h0000);
      $display("tone test done");
      period(8'h40, 0, 8'h00, 4, 0);
      period(8'h40, 0, 8'hFF, 259, 0);
      period(8'h20, 2, 8'h05, 9, 0);
      period(8'h00, 1, 8'h01, 56, 0);
      period(8'h01, 3, 8'h00, 114, 0);
      wr(OFS_CH1_DIVISOR, 8'h03);
      period(8'h50, 1, 8'h01, 266, 2);
      $display("timer test done");
      final_report;
   end
   // Tests need about 2k cycles; 100k means a hang
   initial begin
      #1000000;
      num_errors++;
      final_report;
   end
endmodule
bind audio_timer_channels audio_timer_checker i_chk (.ref_clk(ref_clk),
   .rstn(rstn), .bus_wr(bus_wr), .volume_out(volume_out),
   .timer_pulse(timer_pulse), .init_mode(init_mode),
   .serial_reset(serial_reset));
